//--- logic/pwmart_pkg.sv
// Package: register map, field positions and reset values of the timer
package pwmart_pkg;
	// ==========================================
	// Register indices (byte address is 4x)
	localparam logic [7:0] IDX_DUTY3 = 8'h73;
	localparam logic [7:0] IDX_DUTY2 = 8'h74;
	localparam logic [7:0] IDX_DUTY1 = 8'h75;
	localparam logic [7:0] IDX_DUTY0 = 8'h76;
	localparam logic [7:0] IDX_PWMCTL = 8'h77;
	localparam logic [7:0] IDX_TCS = 8'h78;
	localparam logic [7:0] IDX_LIVE = 8'h79;
	localparam logic [7:0] IDX_RELOAD = 8'h7A;
	localparam logic [7:0] IDX_CCS = 8'h7B;
	localparam logic [7:0] IDX_CAP1 = 8'h7C;
	localparam logic [7:0] IDX_CAP2 = 8'h7D;
	localparam int ADDR_W = 10;
	// ==========================================
	// Control/status field positions
	localparam int TCS_EXT = 7;
	localparam int TCS_PSC_LO = 4;
	localparam int TCS_RUN = 3;
	localparam int TCS_FORCE = 2;
	localparam int TCS_WIE = 1;
	localparam int TCS_WRAP = 0;
	localparam int CCS_EDGE_LO = 4;
	localparam int CCS_IE_LO = 2;
	localparam int CCS_FLAG_LO = 0;
	// ==========================================
	// Reset values and sizes
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [6:0] PSC_ZERO = 7'h00;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam int NUM_PWM = 4;
	localparam int NUM_CAP = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- logic/pwmart_sync.sv
// Two-stage synchroniser for one external level
`timescale 1ns/1ps
module pwmart_sync (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic async_in,
	output logic sync_out
);
	typedef struct packed {
		logic s1;
		logic s2;
	} pwmart_sync_t;
	pwmart_sync_t st, next_st;
	always_comb begin
		next_st.s1 = async_in;
		next_st.s2 = st.s1;
		if (sys_rst_in) begin
			next_st = '0;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		st <= next_st;
	end
	assign sync_out = st.s2;
endmodule

//--- logic/pwmart_chan.sv
// One PWM channel: compare shadow, level generation, pin enable
`timescale 1ns/1ps
module pwmart_chan (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] count_in,
	input wire logic wrap_in,
	input wire logic [7:0] duty_in,
	input wire logic polarity_invert_in,
	input wire logic enable_in,
	output logic pin_out,
	output logic pin_oe_n_out
);
	typedef struct packed {
		logic [7:0] compare_shadow;
		logic pin;
		logic oe_n;
	} pwmart_chan_t;
	pwmart_chan_t st, next_st;
	logic [7:0] cmp_now;
	logic raw_high;
	always_comb begin
		next_st = st;
		// Shadow reloads on wrap only
		cmp_now = wrap_in ? duty_in : st.compare_shadow;
		if (wrap_in) begin
			next_st.compare_shadow = duty_in;
		end
		// Next period start when wrapping
		raw_high = wrap_in ? 1'b1 : (count_in <= cmp_now);
		next_st.pin = raw_high ^ polarity_invert_in;
		next_st.oe_n = ~enable_in;
		if (sys_rst_in) begin
			next_st.compare_shadow = 8'h00;
			next_st.pin = 1'b0;
			next_st.oe_n = 1'b1;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		st <= next_st;
	end
	assign pin_out = st.pin;
	assign pin_oe_n_out = st.oe_n;
endmodule

//--- logic/pwmart_top.sv
// Auto-reload PWM timer with two captures, AXI4-Lite register slave
// How it works
// - Wrap interrupt is flag AND enable
// - Wrap flag clears on status register read
// - Flag sets when counter leaves FF
// - Live counter readable and writable while counting
// - Overflow loads reload value into counter
// - Overflow sets outputs to period-start level
// - Upper nibble enables each PWM pin
// - Output high while counter <= compare
// - Polarity change inverts output at once
// - Duty sets second edge, reload first
// - Capture status bits 7:6 read zero
// - Edge select: zero falling, one rising
// - Per-channel capture interrupt enable
// - Capture flag set, cleared by data read
// - Capture data holds counter, read only
// - All registers reset to zero
// - Prescale codes divide by 1 to 128
// - Force reload loads counter, clears prescaler
// - Hidden compare loads from duty on overflow
// - Capture blocked until data register read
`timescale 1ns/1ps
module pwmart_top #(
	parameter int NUM_PWM = pwmart_pkg::NUM_PWM,
	parameter int NUM_CAP = pwmart_pkg::NUM_CAP
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic [pwmart_pkg::ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [pwmart_pkg::ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic ext_clk_in,
	input wire logic [NUM_CAP-1:0] capture_in_pin_in,
	output logic [NUM_PWM-1:0] pwm_out_pin_out,
	output logic [NUM_PWM-1:0] pwm_out_pin_oe_n_out,
	output logic wrap_irq_out,
	output logic [NUM_CAP-1:0] capture_irq_out
);
	// ==========================================
	// State
	typedef struct packed {
		logic [NUM_PWM-1:0][7:0] pwm_duty_reg;
		logic [3:0] output_en;
		logic [3:0] polarity_invert;
		logic ext_source_sel;
		logic [2:0] prescale_select;
		logic count_run;
		logic wrap_irq_en;
		logic wrap_flag;
		logic [7:0] count;
		logic [7:0] reload_value_reg;
		logic [NUM_CAP-1:0] capture_edge;
		logic [NUM_CAP-1:0] capture_irq_en;
		logic [NUM_CAP-1:0] capture_flag;
		logic [NUM_CAP-1:0][7:0] captured_value;
		logic [6:0] prescaler;
		logic ext_prev;
		logic [NUM_CAP-1:0] cap_prev;
		logic aw_held;
		logic [pwmart_pkg::ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pwmart_top_t;
	pwmart_top_t st, next_st;

	logic ext_sync;
	logic [NUM_CAP-1:0] cap_sync;
	logic [NUM_PWM-1:0] wrap_vec;

	// ==========================================
	// Pin synchronisers
	pwmart_sync u_sync_ext (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in(ext_clk_in),
		.sync_out(ext_sync)
	);
	for (genvar c = 0; c < NUM_CAP; c++) begin : g_cap_sync
		pwmart_sync u_sync_cap (
			.sys_clk_in(sys_clk_in),
			.sys_rst_in(sys_rst_in),
			.async_in(capture_in_pin_in[c]),
			.sync_out(cap_sync[c])
		);
	end

	// ==========================================
	// Main next-state logic
	logic input_tick;
	logic tick;
	logic wrap;
	logic do_write;
	logic do_read;
	logic [7:0] wr_idx;
	logic [7:0] rd_idx;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	logic rd_ok;
	logic wr_ok;
	logic [6:0] psc_mask;
	logic [NUM_CAP-1:0] cap_evt;
	logic [NUM_CAP-1:0] cap_read;
	logic wrap_read;

	always_comb begin
		next_st = st;
		wr_idx = st.aw_addr[pwmart_pkg::ADDR_W-1:2];
		rd_idx = s_axi_araddr_in[pwmart_pkg::ADDR_W-1:2];
		wbyte = st.w_data[7:0];
		do_write = st.aw_held && st.w_held && !st.bvalid;
		do_read = s_axi_arvalid_in && !st.rvalid;
		wrap_read = 1'b0;
		cap_read = '0;
		// Prescaler input: CPU clock or rising edge of external pin
		next_st.ext_prev = ext_sync;
		input_tick = st.ext_source_sel ? (ext_sync && !st.ext_prev) : 1'b1;
		psc_mask = 7'((8'h01 << st.prescale_select) - 8'h01);
		tick = 1'b0;
		if (st.count_run && input_tick) begin
			if ((st.prescaler & psc_mask) == psc_mask) begin
				tick = 1'b1;
				next_st.prescaler = pwmart_pkg::PSC_ZERO;
			end else begin
				next_st.prescaler = st.prescaler + 7'h01;
			end
		end
		wrap = tick && (st.count == pwmart_pkg::CNT_MAX);
		if (tick) begin
			next_st.count = wrap ? st.reload_value_reg :
				st.count + 8'h01;
		end
		// Capture edges
		next_st.cap_prev = cap_sync;
		for (int c = 0; c < NUM_CAP; c++) begin
			cap_evt[c] = st.capture_edge[c] ? (cap_sync[c] && !st.cap_prev[c])
				: (!cap_sync[c] && st.cap_prev[c]);
		end
		// ==========================================
		// Register read
		rd_ok = 1'b1;
		rbyte = 8'h00;
		unique case (rd_idx)
			pwmart_pkg::IDX_DUTY3: rbyte = st.pwm_duty_reg[3];
			pwmart_pkg::IDX_DUTY2: rbyte = st.pwm_duty_reg[2];
			pwmart_pkg::IDX_DUTY1: rbyte = st.pwm_duty_reg[1];
			pwmart_pkg::IDX_DUTY0: rbyte = st.pwm_duty_reg[0];
			pwmart_pkg::IDX_PWMCTL: rbyte = {st.output_en, st.polarity_invert};
			pwmart_pkg::IDX_TCS: begin
				rbyte = {st.ext_source_sel, st.prescale_select, st.count_run,
					1'b0, st.wrap_irq_en, st.wrap_flag};
				wrap_read = do_read;
			end
			pwmart_pkg::IDX_LIVE: rbyte = st.count;
			pwmart_pkg::IDX_RELOAD: rbyte = st.reload_value_reg;
			pwmart_pkg::IDX_CCS: rbyte = {2'b00, st.capture_edge,
				st.capture_irq_en, st.capture_flag};
			pwmart_pkg::IDX_CAP1: begin
				rbyte = st.captured_value[0];
				cap_read[0] = do_read;
			end
			pwmart_pkg::IDX_CAP2: begin
				rbyte = st.captured_value[1];
				cap_read[1] = do_read;
			end
			default: rd_ok = 1'b0;
		endcase
		if (do_read) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = {24'h000000, rbyte};
			next_st.rresp = rd_ok ? pwmart_pkg::RESP_OKAY
				: pwmart_pkg::RESP_SLVERR;
		end else if (st.rvalid && s_axi_rready_in) begin
			next_st.rvalid = 1'b0;
		end
		// Flags: wrap set wins over read clear; a capture event is ignored while its flag is set
		if (wrap_read) begin
			next_st.wrap_flag = 1'b0;
		end
		if (wrap) begin
			next_st.wrap_flag = 1'b1;
		end
		for (int c = 0; c < NUM_CAP; c++) begin
			if (cap_read[c]) begin
				next_st.capture_flag[c] = 1'b0;
			end
			if (cap_evt[c] && !st.capture_flag[c]) begin
				next_st.capture_flag[c] = 1'b1;
				next_st.captured_value[c] = st.count;
			end
		end
		// ==========================================
		// Register write
		if (s_axi_awvalid_in && !st.aw_held) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && !st.w_held) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata_in;
			next_st.w_strb = s_axi_wstrb_in;
		end
		wr_ok = 1'b1;
		if (do_write) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			unique case (wr_idx)
				pwmart_pkg::IDX_DUTY3, pwmart_pkg::IDX_DUTY2,
				pwmart_pkg::IDX_DUTY1, pwmart_pkg::IDX_DUTY0,
				pwmart_pkg::IDX_PWMCTL, pwmart_pkg::IDX_TCS,
				pwmart_pkg::IDX_LIVE, pwmart_pkg::IDX_RELOAD,
				pwmart_pkg::IDX_CCS, pwmart_pkg::IDX_CAP1,
				pwmart_pkg::IDX_CAP2: wr_ok = 1'b1;
				default: wr_ok = 1'b0;
			endcase
			next_st.bresp = wr_ok ? pwmart_pkg::RESP_OKAY
				: pwmart_pkg::RESP_SLVERR;
			if (st.w_strb[0]) begin
				unique case (wr_idx)
					pwmart_pkg::IDX_DUTY3: next_st.pwm_duty_reg[3] = wbyte;
					pwmart_pkg::IDX_DUTY2: next_st.pwm_duty_reg[2] = wbyte;
					pwmart_pkg::IDX_DUTY1: next_st.pwm_duty_reg[1] = wbyte;
					pwmart_pkg::IDX_DUTY0: next_st.pwm_duty_reg[0] = wbyte;
					pwmart_pkg::IDX_PWMCTL: begin
						next_st.output_en = wbyte[7:4];
						next_st.polarity_invert = wbyte[3:0];
					end
					pwmart_pkg::IDX_TCS: begin
						next_st.ext_source_sel = wbyte[pwmart_pkg::TCS_EXT];
						next_st.prescale_select =
							wbyte[pwmart_pkg::TCS_PSC_LO +: 3];
						next_st.count_run = wbyte[pwmart_pkg::TCS_RUN];
						next_st.wrap_irq_en = wbyte[pwmart_pkg::TCS_WIE];
						if (wbyte[pwmart_pkg::TCS_FORCE]) begin
							next_st.count = st.reload_value_reg;
							next_st.prescaler = pwmart_pkg::PSC_ZERO;
						end
					end
					pwmart_pkg::IDX_LIVE: begin
						next_st.count = wbyte;
						next_st.prescaler = pwmart_pkg::PSC_ZERO;
					end
					pwmart_pkg::IDX_RELOAD: next_st.reload_value_reg = wbyte;
					pwmart_pkg::IDX_CCS: begin
						next_st.capture_edge =
							wbyte[pwmart_pkg::CCS_EDGE_LO +: 2];
						next_st.capture_irq_en =
							wbyte[pwmart_pkg::CCS_IE_LO +: 2];
					end
					default: next_st.count = next_st.count;
				endcase
			end
		end
		if (st.bvalid && s_axi_bready_in) begin
			next_st.bvalid = 1'b0;
		end
		if (sys_rst_in) begin
			next_st = '0;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		st <= next_st;
	end

	// ==========================================
	// PWM channels
	for (genvar p = 0; p < NUM_PWM; p++) begin : g_pwm
		assign wrap_vec[p] = wrap;
		pwmart_chan u_chan (
			.sys_clk_in(sys_clk_in),
			.sys_rst_in(sys_rst_in),
			.count_in(next_st.count),
			.wrap_in(wrap_vec[p]),
			.duty_in(st.pwm_duty_reg[p]),
			.polarity_invert_in(next_st.polarity_invert[p]),
			.enable_in(next_st.output_en[p]),
			.pin_out(pwm_out_pin_out[p]),
			.pin_oe_n_out(pwm_out_pin_oe_n_out[p])
		);
	end

	// ==========================================
	// Outputs
	assign s_axi_awready_out = !st.aw_held;
	assign s_axi_wready_out = !st.w_held;
	assign s_axi_bvalid_out = st.bvalid;
	assign s_axi_bresp_out = st.bresp;
	assign s_axi_arready_out = !st.rvalid;
	assign s_axi_rvalid_out = st.rvalid;
	assign s_axi_rdata_out = st.rdata;
	assign s_axi_rresp_out = st.rresp;
	assign wrap_irq_out = st.wrap_flag && st.wrap_irq_en;
	assign capture_irq_out = st.capture_flag & st.capture_irq_en;
endmodule

//--- verif/pwmart_pins.sv
// Pin-side partner: external count clock and capture inputs
`timescale 1ns/1ps
module pwmart_pins (
	input wire logic ext_run_in,
	input wire logic [1:0] cap_level_in,
	output logic ext_clk_out,
	output logic [1:0] capture_out
);
	// ==========================================
	// Free clock source, unrelated to the bus clock
	initial begin
		ext_clk_out = 1'b0;
		capture_out = 2'h0;
		forever begin
			#17.3;
			ext_clk_out = ext_run_in ? ~ext_clk_out : 1'b0;
		end
	end
	// Board delay on the capture lines
	always @(cap_level_in) begin
		capture_out <= #7 cap_level_in;
	end
endmodule

//--- verif/pwmart_monitor.sv
// Port assertions for the PWM timer
`timescale 1ns/1ps
module pwmart_monitor #(
	parameter int NUM_PWM = 4,
	parameter int NUM_CAP = 2
) (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic [pwmart_pkg::ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic s_axi_rvalid_out,
	input wire logic [NUM_PWM-1:0] pwm_out_pin_out,
	input wire logic [NUM_PWM-1:0] pwm_out_pin_oe_n_out,
	input wire logic wrap_irq_out,
	input wire logic [NUM_CAP-1:0] capture_irq_out
);
	// ==========================================
	// Index of the read in flight
	logic [7:0] idx;
	logic rd_new;
	always_ff @(posedge sys_clk_in) begin
		rd_new <= s_axi_arvalid_in && s_axi_arready_out;
		if (s_axi_arvalid_in && s_axi_arready_out) begin
			idx <= s_axi_araddr_in[9:2];
		end
	end
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	// Read answer just raised for index i
	function automatic logic rd_of(input logic [7:0] i);
		return rd_new && (idx == i);
	endfunction
	// ==========================================
	// Assertions
	chk_reset_quiet: assert property (
		$fell(sys_rst_in) |-> !wrap_irq_out && capture_irq_out == '0
		&& pwm_out_pin_out == '0 && &pwm_out_pin_oe_n_out)
		else $error("outputs not idle after reset");
	chk_ccs_reserved: assert property (
		rd_of(pwmart_pkg::IDX_CCS) |-> s_axi_rdata_out[7:6] == 2'h0)
		else $error("reserved capture bits read nonzero");
	chk_force_zero: assert property (
		rd_of(pwmart_pkg::IDX_TCS) |-> !s_axi_rdata_out[2])
		else $error("force bit read nonzero");
	chk_wrap_irq_level: assert property (
		rd_of(pwmart_pkg::IDX_TCS) |-> (s_axi_rdata_out[1]
		& s_axi_rdata_out[0]) == $past(wrap_irq_out))
		else $error("wrap request differs from flag and enable");
	chk_cap_irq_level: assert property (
		rd_of(pwmart_pkg::IDX_CCS) |-> (s_axi_rdata_out[1:0]
		& s_axi_rdata_out[3:2]) == $past(capture_irq_out))
		else $error("capture request differs from flag and enable");
	chk_oe_follow: assert property (
		rd_of(pwmart_pkg::IDX_PWMCTL)
		|-> pwm_out_pin_oe_n_out == ~s_axi_rdata_out[7:4])
		else $error("pin enables differ from control bits");
	chk_wrap_read_clr: assert property (
		rd_of(pwmart_pkg::IDX_TCS) && s_axi_rdata_out[0] |=> !wrap_irq_out)
		else $error("wrap request stays after status read");
	chk_cap_read_clr: assert property (
		rd_of(pwmart_pkg::IDX_CAP1) |-> !capture_irq_out[0] [*2])
		else $error("capture request stays after data read");
	cover property ($rose(wrap_irq_out));
	cover property ($rose(capture_irq_out[0]));
	cover property (rd_of(pwmart_pkg::IDX_TCS));
endmodule
bind pwmart_top pwmart_monitor #(.NUM_PWM(NUM_PWM), .NUM_CAP(NUM_CAP))
	i_mon (.sys_clk_in, .sys_rst_in, .s_axi_araddr_in, .s_axi_arvalid_in,
	.s_axi_arready_out, .s_axi_rdata_out, .s_axi_rvalid_out,
	.pwm_out_pin_out, .pwm_out_pin_oe_n_out, .wrap_irq_out,
	.capture_irq_out);

//--- verif/pwmart_top_tb.sv
// Self-checking bench for the PWM auto-reload timer
`timescale 1ns/1ps
module pwmart_top_tb;
	localparam logic [1:0] OK = pwmart_pkg::RESP_OKAY;
	logic sys_clk_in = 1'b0, sys_rst_in = 1'b1;
	logic [9:0] s_axi_awaddr_in = 10'h000, s_axi_araddr_in = 10'h000;
	logic [31:0] s_axi_wdata_in = 32'h00000000, s_axi_rdata_out;
	logic [3:0] s_axi_wstrb_in = 4'hF, pwm_out_pin_out, pwm_out_pin_oe_n_out;
	logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
	logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0;
	logic s_axi_rready_in = 1'b0, ext_run = 1'b0;
	logic [1:0] cap_level = 2'h0, s_axi_bresp_out, s_axi_rresp_out;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
	logic s_axi_arready_out, s_axi_rvalid_out, wrap_irq_out, ext_clk_in;
	logic [1:0] capture_in_pin_in, capture_irq_out;
	logic [33:0] rd_q[$];
	logic [7:0] rl, dv[4];
	int mismatches = 0, checked = 0, hi, per, n;
	initial forever #2.5 sys_clk_in = ~sys_clk_in;
	pwmart_top i_dut (.sys_clk_in, .sys_rst_in, .s_axi_awaddr_in,
		.s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in,
		.s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
		.s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
		.s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
		.s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
		.s_axi_rready_in, .ext_clk_in, .capture_in_pin_in, .pwm_out_pin_out,
		.pwm_out_pin_oe_n_out, .wrap_irq_out, .capture_irq_out);
	pwmart_pins i_pins (.ext_run_in(ext_run), .cap_level_in(cap_level),
		.ext_clk_out(ext_clk_in), .capture_out(capture_in_pin_in));
	// ==========================================
	// Checking and closing
	task automatic wrap_up();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic stall();
		mismatches++;
		$display("BAD %0t wait ran out", $time);
		wrap_up();
	endtask
	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t bus got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cmp_n(input int got, input int exp);
		checked++;
		if (got != exp) begin
			mismatches++;
			$display("BAD %0t count got %0d want %0d", $time, got, exp);
		end
	endtask
	always @(posedge sys_clk_in) begin
		if (s_axi_rvalid_in_q()) begin
			cmp({s_axi_rresp_out, s_axi_rdata_out}, rd_q.pop_front());
		end
	end
	function automatic logic s_axi_rvalid_in_q();
		return s_axi_rvalid_out === 1'b1 && s_axi_rready_in && rd_q.size() > 0;
	endfunction
	// ==========================================
	// Bus and pin tasks
	task automatic wr(input logic [7:0] i, input logic [7:0] v,
		input logic [1:0] resp);
		int k;
		@(posedge sys_clk_in);
		s_axi_awaddr_in <= {i, 2'h0};
		s_axi_wdata_in <= {24'h000000, v};
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		for (k = 0; k < 50 && s_axi_bvalid_out !== 1'b1; k++) begin
			@(posedge sys_clk_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
		end
		s_axi_bready_in <= 1'b0;
		if (k == 50) stall();
		cmp({s_axi_bresp_out, 32'h0}, {resp, 32'h0});
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] v,
		input logic [1:0] resp);
		int k;
		rd_q.push_back({resp, 24'h000000, v});
		@(posedge sys_clk_in);
		s_axi_araddr_in <= {i, 2'h0};
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		for (k = 0; k < 50 && s_axi_rvalid_out !== 1'b1; k++) begin
			@(posedge sys_clk_in);
			if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
		end
		s_axi_rready_in <= 1'b0;
		if (k == 50) stall();
	endtask
	task automatic hold(input int ch, input logic lvl, output int cnt);
		for (cnt = 0; pwm_out_pin_out[ch] === lvl; cnt++) begin
			@(posedge sys_clk_in);
			if (cnt > 40000) stall();
		end
	endtask
	task automatic measure(input int ch);
		int lo;
		hold(ch, 1'b1, lo);
		hold(ch, 1'b0, lo);
		hold(ch, 1'b1, hi);
		hold(ch, 1'b0, lo);
		per = hi + lo;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		n = $urandom(27);
		repeat (8) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		for (int i = 8'h73; i <= 8'h7D; i++) rd(8'(i), 8'h00, OK);
		rd(8'h00, 8'h00, pwmart_pkg::RESP_SLVERR);
		wr(8'h00, 8'hFF, pwmart_pkg::RESP_SLVERR);
		rl = 8'hF0 + 8'($urandom % 9);
		wr(pwmart_pkg::IDX_RELOAD, rl, OK);
		rd(pwmart_pkg::IDX_RELOAD, rl, OK);
		for (int i = 0; i < 4; i++) begin
			dv[i] = rl + 8'h01 + 8'($urandom % 4);
			wr(pwmart_pkg::IDX_DUTY0 - 8'(i), dv[i], OK);
			rd(pwmart_pkg::IDX_DUTY0 - 8'(i), dv[i], OK);
		end
		s_axi_wstrb_in <= 4'hE;
		wr(pwmart_pkg::IDX_DUTY0, 8'h00, OK);
		s_axi_wstrb_in <= 4'hF;
		rd(pwmart_pkg::IDX_DUTY0, dv[0], OK);
		wr(pwmart_pkg::IDX_CAP1, 8'hA5, OK);
		rd(pwmart_pkg::IDX_CAP1, 8'h00, OK);
		wr(pwmart_pkg::IDX_PWMCTL, 8'hF0, OK);
		rd(pwmart_pkg::IDX_PWMCTL, 8'hF0, OK);
		wr(pwmart_pkg::IDX_LIVE, 8'h5A, OK);
		rd(pwmart_pkg::IDX_LIVE, 8'h5A, OK);
		wr(pwmart_pkg::IDX_TCS, 8'h04, OK);
		rd(pwmart_pkg::IDX_LIVE, rl, OK);
		rd(pwmart_pkg::IDX_TCS, 8'h00, OK);
		for (int c = 0; c < 8; c++) begin
			wr(pwmart_pkg::IDX_TCS, {1'b0, 3'(c), 4'hC}, OK);
			measure(0);
			cmp_n(per, (256 - rl) << c);
			cmp_n(hi, (dv[0] - rl + 1) << c);
		end
		wr(pwmart_pkg::IDX_TCS, 8'h08, OK);
		wr(pwmart_pkg::IDX_PWMCTL, 8'hF1, OK);
		measure(0);
		cmp_n(hi, (256 - rl) - (dv[0] - rl + 1));
		measure(3);
		cmp_n(hi, dv[3] - rl + 1);
		wr(pwmart_pkg::IDX_TCS, 8'h00, OK);
		rd(pwmart_pkg::IDX_TCS, 8'h01, OK);
		rd(pwmart_pkg::IDX_TCS, 8'h00, OK);
		wr(pwmart_pkg::IDX_TCS, 8'h0A, OK);
		measure(0);
		wr(pwmart_pkg::IDX_TCS, 8'h02, OK);
		rd(pwmart_pkg::IDX_TCS, 8'h03, OK);
		rd(pwmart_pkg::IDX_TCS, 8'h02, OK);
		ext_run <= 1'b1;
		wr(pwmart_pkg::IDX_TCS, 8'h88, OK);
		measure(3);
		cmp_n(per > (256 - rl) * 6 && per < (256 - rl) * 8, 1);
		wr(pwmart_pkg::IDX_TCS, 8'h00, OK);
		ext_run <= 1'b0;
		wr(pwmart_pkg::IDX_LIVE, 8'h3C, OK);
		wr(pwmart_pkg::IDX_CCS, 8'h1C, OK);
		cap_level <= 2'b10;
		repeat (12) @(posedge sys_clk_in);
		wr(pwmart_pkg::IDX_LIVE, 8'h5A, OK);
		cap_level <= 2'b01;
		repeat (12) @(posedge sys_clk_in);
		rd(pwmart_pkg::IDX_CCS, 8'h1F, OK);
		wr(pwmart_pkg::IDX_LIVE, 8'h77, OK);
		cap_level <= 2'b00;
		repeat (12) @(posedge sys_clk_in);
		cap_level <= 2'b01;
		repeat (12) @(posedge sys_clk_in);
		rd(pwmart_pkg::IDX_CAP1, 8'h5A, OK);
		wr(pwmart_pkg::IDX_CCS, 8'h10, OK);
		rd(pwmart_pkg::IDX_CCS, 8'h12, OK);
		rd(pwmart_pkg::IDX_CAP2, 8'h5A, OK);
		rd(pwmart_pkg::IDX_CCS, 8'h10, OK);
		wrap_up();
	end
endmodule
